// >>> cib_bus_unit.sv
// cpu internal bus access unit: state timing, decode, rmw, cpu states
`timescale 1ns/100ps
module cib_bus_unit #(
  parameter logic [15:0] ROM_LAST   = 16'hEDFF,
  parameter int unsigned HIGH_DIV   = 1,
  parameter int unsigned MED_DIV    = 8,
  parameter int unsigned SUB_DIV    = 64,
  parameter logic [15:0] UNPOP_DATA = 16'hFFFF,
  parameter logic [7:0]  IO_LOW_UND = 8'hFF
) (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  cib_pkg::cib_exec_type     exec_mode,
  input  cib_pkg::cib_halt_type     halt_mode_sel,
  input  wire logic                 sleep_req,
  input  wire logic                 irq_req,
  output logic                      irq_ack,
  input  wire logic [15:0]          pc_value,
  input  wire logic [7:0]           condition_flags_register,
  input  wire logic [15:0]          stack_pointer_gpr,
  output logic                      sp_update_valid,
  output logic [15:0]               sp_update,
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  cib_pkg::cib_req_type      req,
  output logic                      rsp_valid,
  output logic [15:0]               rsp_data,
  output cib_pkg::cib_cpu_state_type cpu_state,
  output cib_pkg::cib_halt_type     halt_mode,
  output logic                      state_en,
  output logic                      mem_sel,
  output logic                      mem_we,
  output logic [1:0]                mem_be,
  output logic [15:0]               mem_addr,
  output logic [15:0]               mem_wdata,
  input  wire logic [15:0]          mem_rdata,
  output logic                      per_sel,
  output logic                      per_we,
  output logic [15:0]               per_addr,
  output logic [7:0]                per_wdata,
  input  wire logic [7:0]           per_rdata,
  input  wire logic                 per_three
);
  import cib_pkg::*;

  typedef enum logic [1:0] {
    CIB_BUS_IDLE = 2'b00,
    CIB_BUS_T1   = 2'b01,
    CIB_BUS_T2   = 2'b10,
    CIB_BUS_T3   = 2'b11
  } cib_bus_type;

  cib_bus_type       bus_q;
  cib_cpu_state_type cst_q;
  cib_halt_type      halt_q;
  cib_req_type       acc_q;
  cib_region_type    reg_q;
  logic              int_q;
  logic              three_q;
  logic              exc_irq_q;
  logic [1:0]        push_q;
  logic [15:0]       sp_q;
  logic [15:0]       pc_q;
  logic [7:0]        ccr_q;
  logic [7:0]        div_q;
  logic [7:0]        lim;
  logic              stopped;
  logic              use_sub;
  logic              busy;
  logic              start_ext;
  logic              start_int;
  logic              done;
  logic              rmw_turn;
  logic [7:0]        rd_byte;
  logic [7:0]        mod_byte;
  logic [15:0]       rd_word;
  logic [1:0]        st_cnt_q;
  logic              rsp_valid_q;
  logic [15:0]       rsp_data_q;
  logic              irq_ack_q;
  logic [15:0]       sp_upd_q;

  //////////////////////////////////////////////////////////////////////////
  // state clock: one mclk enable per cpu state
  always_comb begin
    use_sub = (cst_q == CIB_CST_HALT) ? (halt_q == CIB_HLT_SUBSLEEP)
                                      : (exec_mode == CIB_EXM_SUB);
    // standby and watch stop the cpu state clock entirely
    stopped = (cst_q == CIB_CST_HALT) &&
              (halt_q == CIB_HLT_STANDBY || halt_q == CIB_HLT_WATCH);
    if (use_sub)
      lim = 8'(SUB_DIV - 1);
    else if (exec_mode == CIB_EXM_MED)
      lim = 8'(MED_DIV - 1);
    else
      lim = 8'(HIGH_DIV - 1);
  end

  always_ff @(posedge mclk) begin
    if (rst || stopped || div_q >= lim)
      div_q <= CIB_DIV_RST;
    else
      div_q <= div_q + 8'h01;
  end

  assign state_en = !stopped && (div_q >= lim);

  //////////////////////////////////////////////////////////////////////////
  // bus cycle sequencing
  assign busy      = (bus_q != CIB_BUS_IDLE);
  // no new request is taken while a cycle is still running
  assign req_ready = !busy && (cst_q == CIB_CST_EXEC) && state_en &&
                     !irq_req && !sleep_req;
  assign start_ext = req_valid && req_ready;
  assign start_int = !busy && state_en && (cst_q == CIB_CST_EXC) &&
                     exc_irq_q && (push_q < CIB_PUSH_CNT);
  assign done      = state_en && ((bus_q == CIB_BUS_T2 && !three_q) ||
                                  bus_q == CIB_BUS_T3);
  assign rmw_turn  = done && (acc_q.bitop != CIB_BOP_NONE) && !acc_q.write;

  always_ff @(posedge mclk) begin
    if (rst)
      bus_q <= CIB_BUS_IDLE;
    else begin
      unique case (bus_q)
        CIB_BUS_IDLE: begin
          if (start_ext || start_int)
            bus_q <= CIB_BUS_T1;
        end
        CIB_BUS_T1: begin
          if (state_en)
            bus_q <= CIB_BUS_T2;
        end
        CIB_BUS_T2: begin
          if (state_en)
            bus_q <= three_q ? CIB_BUS_T3 :
                     (rmw_turn ? CIB_BUS_T1 : CIB_BUS_IDLE);
        end
        CIB_BUS_T3: begin
          if (state_en)
            bus_q <= rmw_turn ? CIB_BUS_T1 : CIB_BUS_IDLE;
        end
      endcase
    end
  end

  // the peripheral decides its length during the first state
  always_ff @(posedge mclk) begin
    if (rst)
      three_q <= 1'b0;
    else if (bus_q == CIB_BUS_T1 && state_en)
      three_q <= (reg_q == CIB_REG_IO) && per_three;
    else if (bus_q == CIB_BUS_IDLE)
      three_q <= 1'b0;
  end

  // latched access; the rmw write reuses the read address
  always_ff @(posedge mclk) begin
    if (rst) begin
      acc_q <= '0;
      reg_q <= CIB_REG_NONE;
      int_q <= 1'b0;
    end else if (start_ext) begin
      acc_q <= req;
      reg_q <= cib_decode(req.addr, ROM_LAST);
      int_q <= 1'b0;
      if (req.bitop != CIB_BOP_NONE) begin
        acc_q.write <= 1'b0;
        acc_q.word  <= 1'b0;
      end
    end else if (start_int) begin
      acc_q.word  <= 1'b1;
      acc_q.write <= 1'b1;
      acc_q.bitop <= CIB_BOP_NONE;
      int_q       <= 1'b1;
      // pc goes below the stack pointer first, then the flags
      if (push_q == 2'h0) begin
        acc_q.addr  <= sp_q - CIB_PUSH_PC;
        acc_q.wdata <= pc_q;
        reg_q       <= cib_decode(sp_q - CIB_PUSH_PC, ROM_LAST);
      end else begin
        acc_q.addr  <= sp_q - CIB_PUSH_FLAGS;
        acc_q.wdata <= {ccr_q, ccr_q};
        reg_q       <= cib_decode(sp_q - CIB_PUSH_FLAGS, ROM_LAST);
      end
    end else if (rmw_turn) begin
      acc_q.write <= 1'b1;
      acc_q.wdata <= {8'h00, mod_byte};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // target ports
  // reserved addresses assert no select, so writes vanish
  assign mem_sel   = busy && (reg_q == CIB_REG_MEM);
  assign per_sel   = busy && (reg_q == CIB_REG_IO);
  assign mem_we    = mem_sel && acc_q.write;
  assign per_we    = per_sel && acc_q.write;
  assign mem_addr  = acc_q.addr;
  assign per_addr  = acc_q.addr;
  // even address is the upper lane of the 16-bit path
  assign mem_be    = acc_q.word ? 2'h3 : (acc_q.addr[0] ? 2'h1 : 2'h2);
  assign mem_wdata = acc_q.word ? acc_q.wdata
                                : {acc_q.wdata[7:0], acc_q.wdata[7:0]};
  // a word write to io keeps only its upper byte
  assign per_wdata = acc_q.word ? acc_q.wdata[15:8] : acc_q.wdata[7:0];

  always_comb begin
    rd_byte = acc_q.addr[0] ? mem_rdata[7:0] : mem_rdata[15:8];
    if (reg_q == CIB_REG_IO)
      rd_byte = per_rdata;
    unique case (reg_q)
      CIB_REG_MEM:
        rd_word = acc_q.word ? mem_rdata : {8'h00, rd_byte};
      CIB_REG_IO:
        // lower half of an io word read carries no data
        rd_word = acc_q.word ? {per_rdata, IO_LOW_UND} : {8'h00, per_rdata};
      default:
        rd_word = UNPOP_DATA;
    endcase
  end

  cib_bit_modify u_bitmod (
    .op      (acc_q.bitop),
    .bitnum  (acc_q.bitnum),
    .carry   (acc_q.carry),
    .rd_byte (rd_byte),
    .wr_byte (mod_byte)
  );

  // answer once per request; an rmw answers after its write half
  always_ff @(posedge mclk) begin
    if (rst) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= CIB_DATA_RST;
    end else begin
      rsp_valid_q <= done && !int_q && !rmw_turn;
      if (done && !acc_q.write)
        rsp_data_q <= rd_word;
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp_data  = rsp_data_q;

  //////////////////////////////////////////////////////////////////////////
  // cpu operating states
  always_ff @(posedge mclk) begin
    if (rst) begin
      cst_q     <= CIB_CST_RESET;
      halt_q    <= CIB_HLT_SLEEP;
      exc_irq_q <= 1'b0;
    end else begin
      unique case (cst_q)
        CIB_CST_RESET: begin
          cst_q     <= CIB_CST_EXC;
          exc_irq_q <= 1'b0;
        end
        CIB_CST_EXEC: begin
          if (!busy && irq_req) begin
            cst_q     <= CIB_CST_EXC;
            exc_irq_q <= 1'b1;
          end else if (!busy && sleep_req) begin
            cst_q  <= CIB_CST_HALT;
            halt_q <= halt_mode_sel;
          end
        end
        CIB_CST_HALT: begin
          if (irq_req) begin
            cst_q     <= CIB_CST_EXC;
            exc_irq_q <= 1'b1;
          end
        end
        CIB_CST_EXC: begin
          if (!exc_irq_q && state_en)
            cst_q <= CIB_CST_EXEC;
          else if (exc_irq_q && !busy && push_q == CIB_PUSH_CNT)
            cst_q <= CIB_CST_EXEC;
        end
      endcase
    end
  end

  // snapshot pc, flags and stack pointer on the way into exception
  always_ff @(posedge mclk) begin
    if (rst) begin
      sp_q  <= CIB_DATA_RST;
      pc_q  <= CIB_DATA_RST;
      ccr_q <= 8'h00;
    end else if (cst_q != CIB_CST_EXC) begin
      sp_q  <= stack_pointer_gpr;
      pc_q  <= pc_value;
      ccr_q <= condition_flags_register;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || cst_q != CIB_CST_EXC)
      push_q <= 2'h0;
    else if (start_int)
      push_q <= push_q + 2'h1;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_ack_q <= 1'b0;
      sp_upd_q  <= CIB_DATA_RST;
    end else begin
      irq_ack_q <= (cst_q == CIB_CST_EXC) && exc_irq_q && !busy &&
                   (push_q == CIB_PUSH_CNT);
      if (cst_q == CIB_CST_EXC && push_q == CIB_PUSH_CNT)
        sp_upd_q <= sp_q - CIB_PUSH_FLAGS;
    end
  end

  assign irq_ack         = irq_ack_q;
  assign sp_update_valid = irq_ack_q;
  assign sp_update       = sp_upd_q;
  assign cpu_state       = cst_q;
  assign halt_mode       = halt_q;

  //////////////////////////////////////////////////////////////////////////
  // checks; st_cnt_q counts the states of the running cycle
  always_ff @(posedge mclk) begin
    if (rst)
      st_cnt_q <= 2'h0;
    else if (start_ext || start_int || rmw_turn)
      st_cnt_q <= 2'h1;
    else if (busy && state_en && !done)
      st_cnt_q <= st_cnt_q + 2'h1;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_mem_two_states: assert property (done && reg_q == CIB_REG_MEM |->
    st_cnt_q == CIB_ST_SHORT) else $error("memory cycle not two states");
  a_per_state_cnt: assert property (done && reg_q == CIB_REG_IO |->
    st_cnt_q == (three_q ? CIB_ST_LONG : CIB_ST_SHORT))
    else $error("peripheral cycle length wrong");
  a_single_target: assert property (!(mem_sel && per_sel))
    else $error("both targets selected");
  a_reserved_quiet: assert property (busy && reg_q == CIB_REG_NONE |->
    !mem_we && !per_we && !mem_sel && !per_sel)
    else $error("reserved access reached a target");
  a_io_word_write: assert property (start_ext && req.word && req.write &&
    req.bitop == CIB_BOP_NONE && cib_decode(req.addr, ROM_LAST) == CIB_REG_IO
    |=> per_we && per_wdata == $past(req.wdata[15:8]))
    else $error("io word write lost upper byte");
  a_rmw_same_addr: assert property (rmw_turn |=>
    acc_q.write && $stable(acc_q.addr) && bus_q == CIB_BUS_T1 &&
    (mem_we || per_we || reg_q == CIB_REG_NONE))
    else $error("rmw write not at read address");
  a_cpu_state_legal: assert property (cst_q == CIB_CST_EXEC |->
    !(bus_q != CIB_BUS_IDLE && int_q)) else $error("push outside exception");
  a_hold_cycle: assert property (busy |-> !req_ready)
    else $error("request taken during a cycle");
  a_push_pc_first: assert property (start_int && push_q == 2'h0 |=>
    mem_addr == sp_q - CIB_PUSH_PC && mem_wdata == pc_q)
    else $error("pc push address wrong");
  a_stop_clock: assert property (stopped |-> !state_en)
    else $error("state clock runs in standby or watch");

  c_three_state: cover property (done && three_q);
  c_rmw_access:  cover property (rmw_turn);
  c_irq_entry:   cover property (irq_ack);
  c_io_word_rd:  cover property (done && reg_q == CIB_REG_IO && acc_q.word);
endmodule

// >>> cib_far_model.sv
// far-side model: on-chip memory words and peripheral register bytes
`timescale 1ns/100ps
module cib_far_model (
  input  wire logic        mclk,
  input  wire logic        state_en,
  input  wire logic        mem_sel,
  input  wire logic        mem_we,
  input  wire logic [1:0]  mem_be,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic [15:0]      mem_rdata,
  input  wire logic        per_sel,
  input  wire logic        per_we,
  input  wire logic [15:0] per_addr,
  input  wire logic [7:0]  per_wdata,
  output logic [7:0]       per_rdata,
  output logic             per_three
);
  logic [15:0] mem [0:32767];
  logic [7:0]  per [0:127];
  logic [15:0] mlast = 16'h0000;
  logic [7:0]  plast = 8'h00;
  // odd registers are the slow ones
  assign per_three = per_addr[0];
  // released data lines show the inverse of the last value, not a hold
  assign mem_rdata = mem_sel ? mem[mem_addr[15:1]] : ~mlast;
  assign per_rdata = per_sel ? per[per_addr[6:0]] : ~plast;
  always @(posedge mclk) begin
    if (mem_sel)
      mlast <= mem_rdata;
    if (per_sel)
      plast <= per_rdata;
    if (mem_sel && mem_we && state_en && mem_be[1])
      mem[mem_addr[15:1]][15:8] <= mem_wdata[15:8];
    if (mem_sel && mem_we && state_en && mem_be[0])
      mem[mem_addr[15:1]][7:0] <= mem_wdata[7:0];
    if (per_sel && per_we && state_en)
      per[per_addr[6:0]] <= per_wdata;
  end
endmodule

// >>> cib_pkg.sv
// package and bit-modify logic for the cpu internal bus access unit
// Functional notes
// - bus timing counts states; one bus cycle lasts two or three states.
// - every on-chip rom or ram access finishes in exactly two states.
// - rom and ram use a 16-bit path, byte or word per cycle.
// - peripheral path is 8 bits, one byte per transfer.
// - peripheral access takes two or three states, chosen by the peripheral.
// - word write to io region stores upper byte, drops lower byte.
// - word read from io region returns byte in upper half; lower undefined.
// - writes to unpopulated space store nothing; data is dropped.
// - reads from unpopulated space return an unpredictable value.
// - rom/ram byte or word in 2 states; io from ff90 byte-only, 2 or 3.
// - bit ops read a byte, change one bit, write byte back same address.
// - cpu is always in exactly one of reset, execute, halt, exception.
// - active modes run on system clock; subactive runs on subclock.
// - halt state has sleep, standby, watch and subsleep sub-modes.
// - interrupt entry uses stack pointer register, pushes pc and flags.
`timescale 1ns/100ps
package cib_pkg;
  typedef enum logic [1:0] {
    CIB_REG_MEM  = 2'b00,
    CIB_REG_IO   = 2'b01,
    CIB_REG_NONE = 2'b10
  } cib_region_type;

  typedef enum logic [1:0] {
    CIB_CST_RESET = 2'b00,
    CIB_CST_EXEC  = 2'b01,
    CIB_CST_HALT  = 2'b10,
    CIB_CST_EXC   = 2'b11
  } cib_cpu_state_type;

  typedef enum logic [1:0] {
    CIB_HLT_SLEEP    = 2'b00,
    CIB_HLT_STANDBY  = 2'b01,
    CIB_HLT_WATCH    = 2'b10,
    CIB_HLT_SUBSLEEP = 2'b11
  } cib_halt_type;

  typedef enum logic [1:0] {
    CIB_EXM_HIGH = 2'b00,
    CIB_EXM_MED  = 2'b01,
    CIB_EXM_SUB  = 2'b10
  } cib_exec_type;

  typedef enum logic [2:0] {
    CIB_BOP_NONE  = 3'b000,
    CIB_BOP_SET   = 3'b001,
    CIB_BOP_CLR   = 3'b010,
    CIB_BOP_INV   = 3'b011,
    CIB_BOP_ST    = 3'b100,
    CIB_BOP_ST_IN = 3'b101
  } cib_bitop_type;

  typedef struct packed {
    logic [15:0]   addr;
    logic [15:0]   wdata;
    logic          word;
    logic          write;
    cib_bitop_type bitop;
    logic [2:0]    bitnum;
    logic          carry;
  } cib_req_type;

  localparam logic [15:0] CIB_ROM_FIRST  = 16'h0000;
  localparam logic [15:0] CIB_RAM_FIRST  = 16'hF780;
  localparam logic [15:0] CIB_RAM_LAST   = 16'hFF7F;
  localparam logic [15:0] CIB_IO_FIRST   = 16'hFF90;
  localparam logic [1:0]  CIB_ST_SHORT   = 2'h2;
  localparam logic [1:0]  CIB_ST_LONG    = 2'h3;
  localparam logic [15:0] CIB_PUSH_PC    = 16'h0002;
  localparam logic [15:0] CIB_PUSH_FLAGS = 16'h0004;
  localparam logic [1:0]  CIB_PUSH_CNT   = 2'h2;
  localparam logic [7:0]  CIB_DIV_RST    = 8'h00;
  localparam logic [15:0] CIB_DATA_RST   = 16'h0000;

  // reserved gaps between rom, ram and io select nothing
  function automatic cib_region_type cib_decode(input logic [15:0] a,
                                                input logic [15:0] rom_last);
    if (a <= rom_last)
      return CIB_REG_MEM;
    else if (a >= CIB_RAM_FIRST && a <= CIB_RAM_LAST)
      return CIB_REG_MEM;
    else if (a >= CIB_IO_FIRST)
      return CIB_REG_IO;
    else
      return CIB_REG_NONE;
  endfunction
endpackage

module cib_bit_modify (
  input  cib_pkg::cib_bitop_type op,
  input  wire logic [2:0]        bitnum,
  input  wire logic              carry,
  input  wire logic [7:0]        rd_byte,
  output logic [7:0]             wr_byte
);
  import cib_pkg::*;
  logic [7:0] mask;
  assign mask = 8'h01 << bitnum;
  // only the chosen bit moves, all others go back as read
  always_comb begin
    unique case (op)
      CIB_BOP_SET:   wr_byte = rd_byte | mask;
      CIB_BOP_CLR:   wr_byte = rd_byte & ~mask;
      CIB_BOP_INV:   wr_byte = rd_byte ^ mask;
      CIB_BOP_ST:    wr_byte = carry ? (rd_byte | mask) : (rd_byte & ~mask);
      CIB_BOP_ST_IN: wr_byte = carry ? (rd_byte & ~mask) : (rd_byte | mask);
      default:       wr_byte = rd_byte;
    endcase
  end
endmodule

// >>> tb_top.sv
// testbench for the cpu internal bus access unit
`timescale 1ns/100ps
module tb_top;
  import cib_pkg::*;
  typedef struct {
    logic [15:0] val;
    logic [15:0] msk;
    int          lat;
    realtime     t;
  } cib_exp_type;
  logic mclk = 1'b0, rst = 1'b1, sleep_req, irq_req, irq_ack, req_valid;
  logic req_ready, rsp_valid, state_en, mem_sel, mem_we, per_sel, per_we;
  logic per_three, sp_update_valid, bn_c;
  logic [15:0] pc_value, stack_pointer_gpr, sp_update, rsp_data, mem_addr;
  logic [15:0] mem_wdata, mem_rdata, per_addr, w;
  logic [7:0]  condition_flags_register, per_wdata, per_rdata, b, nb;
  logic [2:0]  bn;
  logic [1:0]  mem_be;
  cib_exec_type      exec_mode;
  cib_halt_type      halt_mode_sel, halt_mode;
  cib_cpu_state_type cpu_state;
  cib_req_type       req;
  cib_exp_type       q[$];
  int fail_count, checks, tgt, n;
  logic [15:0] alist [8] = '{16'h0000, 16'hEDFF, 16'hEE00, 16'hF780,
                             16'hFF7F, 16'hFF80, 16'hFF90, 16'hFFFF};

  cib_bus_unit #(.MED_DIV(2), .SUB_DIV(3)) dut (.mclk, .rst, .exec_mode,
    .halt_mode_sel, .sleep_req, .irq_req, .irq_ack, .pc_value,
    .condition_flags_register, .stack_pointer_gpr, .sp_update_valid,
    .sp_update, .req_valid, .req_ready, .req, .rsp_valid, .rsp_data,
    .cpu_state, .halt_mode, .state_en, .mem_sel, .mem_we, .mem_be, .mem_addr,
    .mem_wdata, .mem_rdata, .per_sel, .per_we, .per_addr, .per_wdata,
    .per_rdata, .per_three);
  cib_far_model far (.mclk, .state_en, .mem_sel, .mem_we, .mem_be,
    .mem_addr, .mem_wdata, .mem_rdata, .per_sel, .per_we, .per_addr,
    .per_wdata, .per_rdata, .per_three);

  always #2 mclk = ~mclk;

  task automatic cmp16(string s, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic cmp_int(string s, int e, int g);
    checks++;
    if (g != e) begin
      fail_count++;
      $display("mismatch %s expected %0d seen %0d", s, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  function automatic int region(logic [15:0] a);
    if (a <= 16'hEDFF || (a >= 16'hF780 && a <= 16'hFF7F))
      return 0;
    return (a >= 16'hFF90) ? 1 : 2;
  endfunction
  function automatic int st(logic [15:0] a);
    return (region(a) == 1 && a[0]) ? 3 : 2;
  endfunction
  // one request, held from a falling edge until the edge that takes it
  task automatic acc(logic [15:0] a, logic [15:0] wd, logic wo, logic wr,
                     cib_bitop_type op, logic [15:0] ev, logic [15:0] em,
                     int lat);
    int k;
    k = 0;
    @(negedge mclk);
    req = '{a, wd, wo, wr, op, bn, bn_c};
    req_valid = 1'b1;
    tgt = region(a);
    while (req_ready !== 1'b1 && k < 200) begin
      @(negedge mclk);
      k++;
    end
    @(posedge mclk);
    q.push_back('{ev, em, lat, $realtime});
    @(negedge mclk);
    req_valid = 1'b0;
    k = 0;
    while (q.size() > 0 && k < 100) begin
      @(negedge mclk);
      k++;
    end
    cmp_int("answers outstanding", 0, q.size());
  endtask
  task automatic rate(cib_exec_type m, int e);
    int c;
    @(negedge mclk);
    exec_mode = m;
    repeat (4) @(negedge mclk);
    c = 0;
    repeat (24) begin
      @(negedge mclk);
      c += (state_en === 1'b1);
    end
    cmp_int("state_en count", e, c);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(negedge mclk) begin
    cib_exp_type e;
    if (mem_sel === 1'b1 || per_sel === 1'b1)
      cmp_int("target", tgt, per_sel ? 1 : 0);
    if (rsp_valid === 1'b1) begin
      if (q.size() == 0)
        cmp_int("unexpected answer", 0, 1);
      else begin
        e = q.pop_front();
        cmp16("rsp_data", e.val & e.msk, rsp_data & e.msk);
        if (e.lat > 0)
          cmp_int("mclk to answer", e.lat, int'(($realtime-e.t-2)/4));
      end
    end
  end

  initial begin
    #200000;
    fail_count++;
    tally_and_finish;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {sleep_req, irq_req, req_valid, bn_c, bn} = '0;
    req = '0;
    exec_mode = CIB_EXM_HIGH;
    halt_mode_sel = CIB_HLT_SLEEP;
    pc_value = 16'h0000;
    condition_flags_register = 8'h00;
    stack_pointer_gpr = 16'hFF00;
    void'($urandom(32'hC2C6));
    repeat (12) @(negedge mclk);
    cmp16("reset state", CIB_CST_RESET, cpu_state);
    rst = 1'b0;
    n = 0;
    while (cpu_state !== CIB_CST_EXEC && n < 50) begin
      @(negedge mclk);
      n++;
    end
    $display("test reset done");
    // each region written then read back as a byte
    foreach (alist[i]) begin
      b = $urandom;
      w = (region(alist[i]) == 2 || alist[i] <= 16'hEDFF) ? 16'h0 : 16'hFFFF;
      acc(alist[i], {b, b}, 0, 1, CIB_BOP_NONE, 0, 0, st(alist[i]));
      acc(alist[i], 0, 0, 0, CIB_BOP_NONE, {8'h00, b}, w, st(alist[i]));
    end
    $display("test regions done");
    w = $urandom;
    acc(16'hF800, w, 1, 1, CIB_BOP_NONE, 0, 0, 2);
    acc(16'hF800, 0, 1, 0, CIB_BOP_NONE, w, 16'hFFFF, 2);
    acc(16'hF800, 0, 0, 0, CIB_BOP_NONE, w >> 8, 16'hFFFF, 2);
    acc(16'hF801, 0, 0, 0, CIB_BOP_NONE, w & 16'hFF, 16'hFFFF, 2);
    acc(16'hFF92, w, 0, 1, CIB_BOP_NONE, 0, 0, 2);
    acc(16'hFF93, w >> 8, 0, 1, CIB_BOP_NONE, 0, 0, 3);
    acc(16'hFF92, 0, 0, 0, CIB_BOP_NONE, w & 16'hFF, 16'hFFFF, 2);
    acc(16'hFF93, 0, 0, 0, CIB_BOP_NONE, w >> 8, 16'hFFFF, 3);
    acc(16'hFF91, w, 1, 1, CIB_BOP_NONE, 0, 0, 3);
    acc(16'hFF91, 0, 0, 0, CIB_BOP_NONE, w >> 8, 16'hFFFF, 3);
    acc(16'hFF91, 0, 1, 0, CIB_BOP_NONE, w, 16'hFF00, 3);
    $display("test widths done");
    for (int op = 1; op < 6; op++) begin
      foreach (alist[i]) begin
        if (i == 3 || i == 7) begin
          b = $urandom;
          bn = $urandom;
          bn_c = $urandom;
          nb = b;
          case (op)
            1: nb[bn] = 1'b1;
            2: nb[bn] = 1'b0;
            3: nb[bn] = ~b[bn];
            4: nb[bn] = bn_c;
            default: nb[bn] = ~bn_c;
          endcase
          acc(alist[i], {b, b}, 0, 1, CIB_BOP_NONE, 0, 0, 0);
          acc(alist[i], 0, 0, 0, cib_bitop_type'(op), {8'h00, b}, 16'hFFFF,
              2 * st(alist[i]));
          acc(alist[i], 0, 0, 0, CIB_BOP_NONE, {8'h00, nb}, 16'hFFFF, 0);
        end
      end
    end
    $display("test bit ops done");
    rate(CIB_EXM_MED, 12);
    rate(CIB_EXM_SUB, 8);
    rate(CIB_EXM_HIGH, 24);
    $display("test clock rates done");
    for (int m = 0; m < 4; m++) begin
      @(negedge mclk);
      halt_mode_sel = cib_halt_type'(m);
      sleep_req = 1'b1;
      pc_value = $urandom & 16'hFFFE;
      condition_flags_register = $urandom;
      n = 0;
      while (cpu_state !== CIB_CST_HALT && n < 50) begin
        @(negedge mclk);
        n++;
      end
      sleep_req = 1'b0;
      cmp16("cpu_state", CIB_CST_HALT, cpu_state);
      cmp16("halt_mode", m, halt_mode);
      tgt = 0;
      irq_req = 1'b1;
      n = 0;
      b = 0;
      while (irq_ack !== 1'b1 && n < 400) begin
        @(negedge mclk);
        b[0] = b[0] | (cpu_state === CIB_CST_EXC);
        n++;
      end
      irq_req = 1'b0;
      cmp16("exception seen", 1, b);
      cmp16("sp_update_valid", 1, sp_update_valid);
      cmp16("sp_update", 16'hFEFC, sp_update);
      acc(16'hFEFE, 0, 1, 0, CIB_BOP_NONE, pc_value, 16'hFFFF, 2);
      acc(16'hFEFC, 0, 1, 0, CIB_BOP_NONE,
          {2{condition_flags_register}}, 16'hFFFF, 2);
    end
    $display("test halt and interrupt done");
    tally_and_finish;
  end
endmodule
